// ===== verilog/hbsfc_map.svh
// Offsets, field positions, reset values and timing counts of the bridge control block
`ifndef HBSFC_MAP_SVH
`define HBSFC_MAP_SVH

// ****************************************
// Clock and counter widths
// ****************************************
`define HBSFC_CLK_MHZ        200
`define HBSFC_CNT_W          24
`define HBSFC_ADDR_W         8

// ****************************************
// Durations in their own units
// ****************************************
`define HBSFC_IDLE_TIME_US   1000
`define HBSFC_WAKE_TIME_US   250
`define HBSFC_RETRY_TIME_US  2000
`define HBSFC_OCP_TIME_NS    1000
`define HBSFC_DEAD_TIME_NS   200

// ****************************************
// Durations in core clock cycles
// ****************************************
`define HBSFC_IDLE_CYC       (`HBSFC_IDLE_TIME_US * `HBSFC_CLK_MHZ)
`define HBSFC_WAKE_CYC       (`HBSFC_WAKE_TIME_US * `HBSFC_CLK_MHZ)
`define HBSFC_RETRY_CYC      (`HBSFC_RETRY_TIME_US * `HBSFC_CLK_MHZ)
`define HBSFC_OCP_CYC        ((`HBSFC_OCP_TIME_NS * `HBSFC_CLK_MHZ + 999) / 1000)
`define HBSFC_DEAD_CYC       ((`HBSFC_DEAD_TIME_NS * `HBSFC_CLK_MHZ + 999) / 1000)

// ****************************************
// Register map
// ****************************************
`define HBSFC_CTRL_OFS       8'h00
`define HBSFC_STAT_OFS       8'h04
`define HBSFC_CTRL_EN_POS    0
`define HBSFC_CTRL_EN_RST    1'b1
`define HBSFC_STAT_LOCK_POS  0
`define HBSFC_STAT_SLEEP_POS 1
`define HBSFC_STAT_IDLE_POS  2
`define HBSFC_STAT_ACT_POS   3
`define HBSFC_STAT_AUTO_POS  4
`define HBSFC_STAT_DIS_POS   5
`define HBSFC_STAT_THERM_POS 7
`define HBSFC_STAT_MODE_POS  8
`define HBSFC_STAT_HS_POS    10
`define HBSFC_STAT_LS_POS    12

`endif

// ===== verilog/hbsfc_pkg.sv
// Types shared by the bridge control block
`include "hbsfc_map.svh"
package hbsfc_pkg;

	typedef enum logic [1:0] {ST_LOCK, ST_SLEEP, ST_ACTIVE, ST_IDLE} hbsfc_state_t;
	typedef enum logic [1:0] {DRV_OFF, DRV_LOW, DRV_HIGH} hbsfc_drv_t;
	typedef enum logic [1:0] {MODE_PWM, MODE_DIRSPD, MODE_HALF} hbsfc_mode_t;

	typedef struct packed {
		logic                     psel;
		logic                     penable;
		logic                     pwrite;
		logic [`HBSFC_ADDR_W-1:0] paddr;
		logic [31:0]              pwdata;
	} hbsfc_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} hbsfc_apb_rsp_t;

	typedef struct packed {
		logic [1:0] hs_on;
		logic [1:0] ls_on;
	} hbsfc_gate_t;

	typedef struct packed {
		hbsfc_state_t                 st;
		logic                         auto_slp;
		logic [`HBSFC_CNT_W-1:0]      tmr;
		logic [1:0][`HBSFC_CNT_W-1:0] oc_cnt;
		logic [`HBSFC_CNT_W-1:0]      retry_cnt;
		logic [1:0]                   dis;
		hbsfc_drv_t [1:0]             cur;
		logic [1:0][`HBSFC_CNT_W-1:0] dcnt;
		logic                         sw_en;
		hbsfc_apb_rsp_t               rsp;
		hbsfc_gate_t                  gate;
		logic                         cp_en;
		logic                         bias_en;
	} hbsfc_regs_t;

endpackage

// ===== verilog/hbsfc_top.sv
// Bridge sleep, wake, protection and gate control with APB control and status registers
`timescale 1ns/100ps
`include "hbsfc_map.svh"

module hbsfc_top
	import hbsfc_pkg::*;
#(
	parameter logic [`HBSFC_CNT_W-1:0] IDLE_CYC  = `HBSFC_CNT_W'(`HBSFC_IDLE_CYC),
	parameter logic [`HBSFC_CNT_W-1:0] WAKE_CYC  = `HBSFC_CNT_W'(`HBSFC_WAKE_CYC),
	parameter logic [`HBSFC_CNT_W-1:0] RETRY_CYC = `HBSFC_CNT_W'(`HBSFC_RETRY_CYC),
	parameter logic [`HBSFC_CNT_W-1:0] OCP_CYC   = `HBSFC_CNT_W'(`HBSFC_OCP_CYC),
	parameter logic [`HBSFC_CNT_W-1:0] DEAD_CYC  = `HBSFC_CNT_W'(`HBSFC_DEAD_CYC)
) (
	// Clock and reset
	input  wire logic           core_clk,
	input  wire logic           nrst,
	// Register bus
	input  wire hbsfc_apb_req_t apb_req,
	output      hbsfc_apb_rsp_t apb_rsp,
	// Control inputs from the controller
	input  wire logic           standby_pin_n,
	input  wire logic           shared_input_a,
	input  wire logic           shared_input_b,
	input  wire logic           mode_at_rail,
	input  wire logic           mode_at_ground,
	// Comparator outputs
	input  wire logic           supply_low_lockout,
	input  wire logic [1:0]     overcurrent_trip,
	input  wire logic           thermal_trip,
	// Power stage
	output      hbsfc_gate_t    gate,
	output      logic           charge_pump_en,
	output      logic           mode_bias_en
);

	hbsfc_regs_t q;
	hbsfc_regs_t n;
	hbsfc_mode_t mode;
	logic        auto_combo;
	logic        run;
	logic [1:0]  new_trip;
	hbsfc_drv_t  tgt [2];
	logic [31:0] stat_word;

	// ****************************************
	// Register file and state
	// ****************************************
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			q       <= '0;
			q.sw_en <= `HBSFC_CTRL_EN_RST;
		end else begin
			q <= n;
		end
	end

	always_comb begin
		n = q;

		// Mode decode; both comparators high cannot occur, treated as PWM
		if (mode_at_ground || (mode_at_rail && mode_at_ground)) begin
			mode = MODE_PWM;
		end else if (mode_at_rail) begin
			mode = MODE_DIRSPD;
		end else begin
			mode = MODE_HALF;
		end

		unique case (mode)
			MODE_PWM:    auto_combo = !shared_input_a && !shared_input_b;
			MODE_DIRSPD: auto_combo = !shared_input_b;
			MODE_HALF:   auto_combo = 1'b0;
		endcase

		// ****************************************
		// APB slave, one wait state
		// ****************************************
		stat_word = '0;
		stat_word[`HBSFC_STAT_LOCK_POS]  = (q.st == ST_LOCK);
		stat_word[`HBSFC_STAT_SLEEP_POS] = (q.st == ST_SLEEP);
		stat_word[`HBSFC_STAT_IDLE_POS]  = (q.st == ST_IDLE);
		stat_word[`HBSFC_STAT_ACT_POS]   = (q.st == ST_ACTIVE);
		stat_word[`HBSFC_STAT_AUTO_POS]  = q.auto_slp;
		stat_word[`HBSFC_STAT_DIS_POS +: 2]   = q.dis;
		stat_word[`HBSFC_STAT_THERM_POS]      = thermal_trip;
		stat_word[`HBSFC_STAT_MODE_POS +: 2]  = mode;
		stat_word[`HBSFC_STAT_HS_POS +: 2]    = q.gate.hs_on;
		stat_word[`HBSFC_STAT_LS_POS +: 2]    = q.gate.ls_on;

		n.rsp = '0;
		if (apb_req.psel && apb_req.penable && !q.rsp.pready) begin
			n.rsp.pready = 1'b1;
			if (apb_req.paddr == `HBSFC_CTRL_OFS) begin
				n.rsp.prdata[`HBSFC_CTRL_EN_POS] = q.sw_en;
			end else if (apb_req.paddr == `HBSFC_STAT_OFS) begin
				n.rsp.prdata = apb_req.pwrite ? 32'h0000_0000 : stat_word;
				n.rsp.pslverr = apb_req.pwrite;
			end else begin
				n.rsp.pslverr = 1'b1;
			end
		end
		// Write lands on the completing edge only
		if (apb_req.psel && apb_req.penable && q.rsp.pready && apb_req.pwrite
			&& apb_req.paddr == `HBSFC_CTRL_OFS) begin
			n.sw_en = apb_req.pwdata[`HBSFC_CTRL_EN_POS];
		end

		// ****************************************
		// Sleep, wake and lockout sequencing
		// ****************************************
		unique case (q.st)
			ST_LOCK: begin
				n.tmr = '0;
				n.st  = ST_ACTIVE;
			end
			ST_SLEEP: begin
				if (!standby_pin_n) begin
					n.auto_slp = 1'b0;
				end
				// Same hold serves pin wake and auto wake
				if (standby_pin_n && !auto_combo) begin
					if (q.tmr >= WAKE_CYC - 1'b1) begin
						n.st       = ST_ACTIVE;
						n.tmr      = '0;
						n.auto_slp = 1'b0;
					end else begin
						n.tmr = q.tmr + 1'b1;
					end
				end else begin
					n.tmr = '0;
				end
			end
			ST_ACTIVE: begin
				n.tmr = '0;
				if (!standby_pin_n) begin
					n.st = ST_SLEEP;
				end else if (auto_combo) begin
					n.st = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (!standby_pin_n) begin
					n.st  = ST_SLEEP;
					n.tmr = '0;
				end else if (!auto_combo) begin
					n.st  = ST_ACTIVE;
					n.tmr = '0;
				end else if (q.tmr >= IDLE_CYC - 1'b1) begin
					n.st       = ST_SLEEP;
					n.auto_slp = 1'b1;
					n.tmr      = '0;
				end else begin
					n.tmr = q.tmr + 1'b1;
				end
			end
		endcase

		// ****************************************
		// Overcurrent filter and shared retry
		// ****************************************
		new_trip = 2'b00;
		for (int i = 0; i < 2; i++) begin
			if (overcurrent_trip[i] && q.cur[i] != DRV_OFF && !q.dis[i]) begin
				if (q.oc_cnt[i] >= OCP_CYC - 1'b1) begin
					new_trip[i]  = 1'b1;
					n.oc_cnt[i]  = '0;
				end else begin
					n.oc_cnt[i] = q.oc_cnt[i] + 1'b1;
				end
			end else begin
				n.oc_cnt[i] = '0;
			end
		end

		if (new_trip != 2'b00) begin
			// A later trip restarts the full period for everything disabled
			n.dis       = (mode == MODE_HALF) ? (q.dis | new_trip) : 2'b11;
			n.retry_cnt = RETRY_CYC;
		end else if (q.dis != 2'b00) begin
			if (q.retry_cnt <= 1) begin
				n.dis       = 2'b00;
				n.retry_cnt = '0;
			end else begin
				n.retry_cnt = q.retry_cnt - 1'b1;
			end
		end

		// ****************************************
		// Lockout overrides everything
		// ****************************************
		if (supply_low_lockout) begin
			n.st        = ST_LOCK;
			n.tmr       = '0;
			n.auto_slp  = 1'b0;
			n.oc_cnt    = '0;
			n.dis       = 2'b00;
			n.retry_cnt = '0;
		end

		// ****************************************
		// Drive targets from the truth tables
		// ****************************************
		run = (q.st == ST_ACTIVE || q.st == ST_IDLE) && !supply_low_lockout && q.sw_en
			&& !thermal_trip;
		unique case (mode)
			MODE_PWM: begin
				unique case ({shared_input_a, shared_input_b})
					2'b00: begin
						tgt[0] = DRV_OFF;
						tgt[1] = DRV_OFF;
					end
					2'b01: begin
						tgt[0] = DRV_LOW;
						tgt[1] = DRV_HIGH;
					end
					2'b10: begin
						tgt[0] = DRV_HIGH;
						tgt[1] = DRV_LOW;
					end
					2'b11: begin
						tgt[0] = DRV_LOW;
						tgt[1] = DRV_LOW;
					end
				endcase
			end
			MODE_DIRSPD: begin
				if (!shared_input_b) begin
					tgt[0] = DRV_LOW;
					tgt[1] = DRV_LOW;
				end else begin
					tgt[0] = shared_input_a ? DRV_HIGH : DRV_LOW;
					tgt[1] = shared_input_a ? DRV_LOW : DRV_HIGH;
				end
			end
			MODE_HALF: begin
				tgt[0] = shared_input_a ? DRV_HIGH : DRV_LOW;
				tgt[1] = shared_input_b ? DRV_HIGH : DRV_LOW;
			end
		endcase

		// ****************************************
		// Dead time and gate drive
		// ****************************************
		for (int i = 0; i < 2; i++) begin
			if (!run || q.dis[i]) begin
				tgt[i] = DRV_OFF;
			end
			if (q.dcnt[i] != '0) begin
				n.dcnt[i] = q.dcnt[i] - 1'b1;
			end
			// Turning off is immediate; turning on waits out the dead time
			if (tgt[i] != q.cur[i]) begin
				if (q.cur[i] != DRV_OFF) begin
					n.cur[i]  = DRV_OFF;
					n.dcnt[i] = DEAD_CYC;
				end else if (q.dcnt[i] == '0) begin
					n.cur[i] = tgt[i];
				end
			end
			n.gate.hs_on[i] = (n.cur[i] == DRV_HIGH);
			n.gate.ls_on[i] = (n.cur[i] == DRV_LOW);
		end

		n.cp_en   = (n.st == ST_ACTIVE || n.st == ST_IDLE);
		n.bias_en = !(n.st == ST_SLEEP && n.auto_slp);
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign apb_rsp        = q.rsp;
	assign gate           = q.gate;
	assign charge_pump_en = q.cp_en;
	assign mode_bias_en   = q.bias_en;

endmodule

// ===== tb/hbsfc_assertions.sv
// Port-level checks of the bridge control block
`timescale 1ns/100ps
module hbsfc_assertions
	import hbsfc_pkg::*;
#(
	parameter logic [23:0] OCP_CYC = 24'hC8
) (
	// Clock and reset
	input wire logic           core_clk,
	input wire logic           nrst,
	// Register bus
	input wire hbsfc_apb_req_t apb_req,
	input wire hbsfc_apb_rsp_t apb_rsp,
	// Controller pins
	input wire logic           standby_pin_n,
	input wire logic           shared_input_a,
	input wire logic           shared_input_b,
	input wire logic           mode_at_rail,
	input wire logic           mode_at_ground,
	// Comparators
	input wire logic           supply_low_lockout,
	input wire logic [1:0]     overcurrent_trip,
	input wire logic           thermal_trip,
	// Power stage
	input wire hbsfc_gate_t    gate,
	input wire logic           charge_pump_en,
	input wire logic           mode_bias_en
);
	logic [23:0] oc_run_q;
	wire         gate_off = (gate == 4'h0);
	wire         trip_on  = (mode_at_rail || mode_at_ground) && overcurrent_trip[0] && (gate.hs_on[0] || gate.ls_on[0]);

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	// Trip run on half 0 while it drives, outside half-bridge mode; a count, since the filter is far past any repetition
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			oc_run_q <= 24'h0;
		else
			oc_run_q <= trip_on ? oc_run_q + 24'h1 : 24'h0;
	end

	sequence coast_s;
		mode_at_ground && !shared_input_a && !shared_input_b;
	endsequence
	sequence brake_s;
		mode_at_rail && !mode_at_ground && !shared_input_b;
	endsequence
	sequence pin_drop_s;
		charge_pump_en && !standby_pin_n ##1 standby_pin_n;
	endsequence

	lock_off_a: assert property (supply_low_lockout |=> gate_off && !charge_pump_en) else $error("gates on in lockout");
	lock_exit_a: assert property ($fell(supply_low_lockout) && standby_pin_n |-> ##[1:3] charge_pump_en) else $error("no exit");
	ocp_off_a: assert property (oc_run_q == OCP_CYC |-> ##[0:4] gate_off ##1 gate_off [*8]) else $error("trip ignored");
	therm_off_a: assert property (thermal_trip |=> gate_off) else $error("gates on in overheat");
	pin_sleep_a: assert property (charge_pump_en && !standby_pin_n |=> !charge_pump_en ##1 gate_off) else $error("late sleep");
	wake_hold_a: assert property (pin_drop_s |=> !charge_pump_en [*8]) else $error("woke too early");
	coast_idle_a: assert property (coast_s [*3] |=> gate_off) else $error("coast not off");
	brake_low_a: assert property (brake_s [*3] |=> gate.hs_on == 2'h0) else $error("high side on in brake");
	no_shoot_a: assert property ((gate.hs_on & gate.ls_on) == 2'h0) else $error("both sides on");
	dead_time_a: assert property ($fell(gate.hs_on[0]) |-> !gate.ls_on[0] [*3]) else $error("no dead time");
endmodule

bind hbsfc_top hbsfc_assertions #(.OCP_CYC(OCP_CYC)) i_hbsfc_assertions (.core_clk, .nrst, .apb_req, .apb_rsp,
	.standby_pin_n, .shared_input_a, .shared_input_b, .mode_at_rail, .mode_at_ground, .supply_low_lockout,
	.overcurrent_trip, .thermal_trip, .gate, .charge_pump_en, .mode_bias_en);

// ===== tb/hbsfc_mcu.sv
// Controller model driving the logic pins of the bridge block
`timescale 1ns/100ps
module hbsfc_mcu (
	// Clock
	input  wire logic       core_clk,
	// Wanted levels
	input  wire logic       want_n,
	input  wire logic       want_a,
	input  wire logic       want_b,
	input  wire logic [1:0] want_mode,
	// Pins
	output logic            standby_pin_n,
	output logic            shared_input_a,
	output logic            shared_input_b,
	output logic            mode_at_rail,
	output logic            mode_at_ground
);
	// Pins are driven from time zero, never left floating
	initial begin
		standby_pin_n = 1'b1;
		{shared_input_a, shared_input_b, mode_at_rail, mode_at_ground} = 4'h9;
	end
	always @(posedge core_clk) begin
		standby_pin_n  <= want_n;
		shared_input_a <= want_a;
		shared_input_b <= want_b;
		mode_at_rail   <= (want_mode == 2'h1);
		mode_at_ground <= (want_mode == 2'h0);
	end
endmodule

// ===== tb/test_hbsfc_top.sv
// Self-checking bench of the bridge control block
`timescale 1ns/100ps
module test_hbsfc_top
	import hbsfc_pkg::*;
;
	logic           core_clk, nrst, want_n, want_a, want_b, supply_low_lockout, thermal_trip, a, b;
	logic           standby_pin_n, shared_input_a, shared_input_b, mode_at_rail, mode_at_ground;
	logic           charge_pump_en, mode_bias_en;
	logic [1:0]     want_mode, overcurrent_trip, m;
	logic [3:0]     eg;
	hbsfc_apb_req_t apb_req;
	hbsfc_apb_rsp_t apb_rsp;
	hbsfc_gate_t    gate;
	logic [64:0]    notes[$];
	logic [64:0]    nt;
	int             fail_count, compares, i;

	hbsfc_mcu i_hbsfc_mcu (.core_clk, .want_n, .want_a, .want_b, .want_mode, .standby_pin_n, .shared_input_a,
		.shared_input_b, .mode_at_rail, .mode_at_ground);
	hbsfc_top #(.IDLE_CYC(24'h14), .WAKE_CYC(24'hA), .RETRY_CYC(24'h1E), .OCP_CYC(24'h4), .DEAD_CYC(24'h3))
	i_hbsfc_top (.core_clk, .nrst, .apb_req, .apb_rsp, .standby_pin_n, .shared_input_a, .shared_input_b,
		.mode_at_rail, .mode_at_ground, .supply_low_lockout, .overcurrent_trip, .thermal_trip, .gate,
		.charge_pump_en, .mode_bias_en);

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// ****
	// Helpers
	// ****
	function automatic logic [3:0] fwd(input logic [1:0] md, input logic pa, pb);
		case (md)
			2'h0: return (pa ^ pb) ? {pb, pa, pa, pb} : {2'h0, pa, pa};
			2'h1: return pb ? {~pa, pa, pa, ~pa} : 4'h3;
			default: return {pb, pa, ~pb, ~pa};
		endcase
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, s);
		compares++;
		if (s !== e) begin
			$display("unexpected %s expected %h seen %h", nm, e, s);
			fail_count++;
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	// Gates and pump looked at mid-cycle, away from the launching edge
	task automatic look(input int n, input logic [3:0] e, input logic c);
		step(n);
		@(negedge core_clk);
		chk("gate", {28'h0, e}, {28'h0, gate});
		chk("pump", {31'h0, c}, {31'h0, charge_pump_en});
		@(posedge core_clk);
	endtask

	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d, e, mk, input logic er);
		int k;
		notes.push_back({er, mk, e});
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: ad, pwdata: d};
		@(posedge core_clk);
		apb_req.penable <= 1'b1;
		k = 0;
		do begin
			@(negedge core_clk);
			k++;
		end while (apb_rsp.pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			$display("unexpected pready expected 1 seen 0");
			fail_count++;
			stop_test();
		end
		@(posedge core_clk);
		apb_req <= '0;
		@(posedge core_clk);
	endtask

	task automatic stop_test();
		$display("mismatches %0d compares %0d", fail_count, compares);
		if (fail_count == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	always @(negedge core_clk) begin
		if (apb_rsp.pready === 1'b1) begin
			nt = notes.pop_front();
			chk("prdata", nt[31:0], apb_rsp.prdata & nt[63:32]);
			chk("pslverr", {31'h0, nt[64]}, {31'h0, apb_rsp.pslverr});
		end
	end

	initial begin
		nrst = 1'b0;
		apb_req = '0;
		{want_n, want_a, want_b, want_mode} = 5'h18;
		{supply_low_lockout, thermal_trip, overcurrent_trip} = 4'h0;
		fail_count = 0;
		compares = 0;
		void'($urandom(93));
		step(16);
		nrst <= 1'b1;
		step(2);
		apb(1'b0, 8'h00, 32'h0, 32'h1, 32'hFFFFFFFF, 1'b0);
		apb(1'b1, 8'h00, 32'h0, 32'h0, 32'h0, 1'b0);
		look(3, 4'h0, 1'b1);
		apb(1'b1, 8'h04, 32'hFFFF, 32'h0, 32'h0, 1'b1);
		apb(1'b0, 8'h10, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b1);
		apb(1'b1, 8'h00, 32'h1, 32'h0, 32'h0, 1'b0);
		for (i = 0; i < 24; i++) begin
			m = 2'($urandom_range(2));
			a = 1'($urandom);
			b = 1'($urandom);
			// Idle combinations are kept for the sleep scenarios
			if (m != 2'h2 && !b && (m == 2'h1 || !a))
				b = 1'b1;
			want_mode <= m;
			want_a <= a;
			want_b <= b;
			eg = fwd(m, a, b);
			look(12, eg, 1'b1);
			apb(1'b0, 8'h04, 32'h0, {18'h0, eg[1:0], eg[3:2], m, 8'h08}, 32'h3F08, 1'b0);
		end
		{want_mode, want_a, want_b} <= 4'h0;
		look(6, 4'h0, 1'b1);
		apb(1'b0, 8'h04, 32'h0, 32'h04, 32'h16, 1'b0);
		step(25);
		apb(1'b0, 8'h04, 32'h0, 32'h12, 32'h16, 1'b0);
		@(negedge core_clk);
		chk("bias", 32'h0, {31'h0, mode_bias_en});
		@(posedge core_clk);
		want_a <= 1'b1;
		look(5, 4'h0, 1'b0);
		look(15, fwd(2'h0, 1'b1, 1'b0), 1'b1);
		{want_mode, want_a, want_b} <= 4'h4;
		look(10, 4'h3, 1'b1);
		look(25, 4'h0, 1'b0);
		want_b <= 1'b1;
		look(20, fwd(2'h1, 1'b0, 1'b1), 1'b1);
		want_n <= 1'b0;
		look(4, 4'h0, 1'b0);
		want_n <= 1'b1;
		look(5, 4'h0, 1'b0);
		look(15, fwd(2'h1, 1'b0, 1'b1), 1'b1);
		// One-cycle standby glitch still needs the full wake hold
		want_n <= 1'b0;
		step(1);
		want_n <= 1'b1;
		look(5, 4'h0, 1'b0);
		look(15, fwd(2'h1, 1'b0, 1'b1), 1'b1);
		overcurrent_trip <= 2'h1;
		look(10, 4'h0, 1'b1);
		apb(1'b0, 8'h04, 32'h0, 32'h60, 32'h60, 1'b0);
		overcurrent_trip <= 2'h0;
		look(35, fwd(2'h1, 1'b0, 1'b1), 1'b1);
		{want_mode, want_a, want_b} <= 4'hB;
		look(10, 4'hC, 1'b1);
		overcurrent_trip <= 2'h1;
		look(10, 4'h8, 1'b1);
		overcurrent_trip <= 2'h0;
		step(14);
		overcurrent_trip <= 2'h2;
		look(10, 4'h0, 1'b1);
		overcurrent_trip <= 2'h0;
		look(10, 4'h0, 1'b1);
		look(30, 4'hC, 1'b1);
		thermal_trip <= 1'b1;
		look(3, 4'h0, 1'b1);
		apb(1'b0, 8'h04, 32'h0, 32'h80, 32'h80, 1'b0);
		thermal_trip <= 1'b0;
		look(8, 4'hC, 1'b1);
		supply_low_lockout <= 1'b1;
		look(3, 4'h0, 1'b0);
		apb(1'b0, 8'h04, 32'h0, 32'h01, 32'h01, 1'b0);
		supply_low_lockout <= 1'b0;
		look(8, 4'hC, 1'b1);
		stop_test();
	end
endmodule
